// file: core/xsti_pkg.sv
package xsti_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRANS_TIME_NS = 40;
  localparam int TRANS_CYCLES = TRANS_TIME_NS / CLK_PERIOD_NS;
  localparam int TRIG_TIME_NS = 20;
  localparam int TRIG_CYCLES = TRIG_TIME_NS / CLK_PERIOD_NS;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] REG_STATUS = 6'h01;
  localparam logic [5:0] REG_CONTROL = 6'h02;
  localparam logic [5:0] REG_MASK = 6'h0e;
  localparam logic [5:0] REG_EVENTS = 6'h0f;

  localparam int CFG_N = 9;
  localparam logic [5:0] CFG_ADDR [CFG_N] = '{6'h04, 6'h08, 6'h09, 6'h17,
                                              6'h19, 6'h2c, 6'h2d, 6'h2e,
                                              6'h2f};
  localparam int CFG_IDX_RETRIES = 5;
  localparam int SLOTTED_BIT = 0;

  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_RESULT_BIT = 6;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int EVT_START_BIT = 2;
  localparam int EVT_END_BIT = 3;
  localparam int EVT_CCA_BIT = 4;
  localparam int EVT_MATCH_BIT = 5;

  localparam logic [2:0] RES_SUCCESS = 3'h0;
  localparam logic [2:0] RES_OK_PENDING_DATA = 3'h1;
  localparam logic [2:0] RES_OK_ACK_PENDING_SLOT = 3'h2;
  localparam logic [2:0] RES_CHANNEL_BUSY_FAILURE = 3'h3;
  localparam logic [2:0] RES_NO_ACK = 3'h5;
  localparam logic [2:0] RES_INVALID = 3'h7;

  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
  localparam logic [4:0] CMD_FORCE_PLL_ON = 5'h04;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_OFF = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_DEEP_PREP = 5'h10;
  localparam logic [4:0] CMD_AUTO_ACK_RX_ON = 5'h16;
  localparam logic [4:0] CMD_AUTO_RETRY_TX_ON = 5'h19;

  typedef enum logic [4:0] {
    ST_POWER_ON = 5'h00,
    ST_RX_BUSY = 5'h01,
    ST_TX_BUSY = 5'h02,
    ST_RX_ON = 5'h06,
    ST_OFF = 5'h08,
    ST_PLL_ON = 5'h09,
    ST_SLEEP = 5'h0f,
    ST_DEEP_SLEEP_PREPARATION = 5'h10,
    ST_AUTO_ACK_RX_BUSY = 5'h11,
    ST_AUTO_RETRY_TX_BUSY = 5'h12,
    ST_AUTO_ACK_RX_IDLE = 5'h16,
    ST_AUTO_RETRY_TX_IDLE = 5'h19,
    ST_DEEP_SLEEP = 5'h1e,
    ST_STATE_CHANGING = 5'h1f
  } xsti_state_t;

  localparam logic [3:0] HOST_REG_CMD = 4'h0;
  localparam logic [3:0] HOST_REG_STAT = 4'h4;
  localparam logic [3:0] HOST_REG_TRIG = 4'h8;
  localparam int HCMD_ADDR_LSB = 8;
  localparam int HCMD_READ_BIT = 16;
  localparam int HSTAT_RDATA_LSB = 8;
  localparam int HSTAT_IRQ_BIT = 16;
  localparam int HSTAT_REFUSED_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: core/xsti_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xsti_link_if;
  logic [5:0] regAddr;
  logic [7:0] regWdata;
  logic regWe;
  logic regRe;
  logic [7:0] regRdata;
  logic regRvalid;
  logic trigPin;
  logic irqPin;

  modport device (
    input regAddr, regWdata, regWe, regRe, trigPin,
    output regRdata, regRvalid, irqPin
  );
  modport host (
    output regAddr, regWdata, regWe, regRe, trigPin,
    input regRdata, regRvalid, irqPin
  );
endinterface
`default_nettype wire

// file: core/xsti_device.sv
// What this block does
// - Auto-ack frame end needs address match, good FCS
// - Auto-ack frame start on valid PHY header
// - Auto-ack address match raises its event
// - Failed FCS may leave start without end
// - Auto-retry completion always raises end, stores result
// - No Clear_channel_check_done event during auto-retry
// - No start or match during auto-retry ack wait
// - Read-only status, state code in bits 4:0
// - Basic state codes as encoded
// - Extended state codes, transition code 0x1F
// - Status unreachable in sleep or deep sleep
// - Host waits while state reads changing
// - Command write starts a state change
// - Trigger pin rising edge starts some transitions
// - Control register: result 7:5, command 4:0
// - Transaction result codes as encoded
// - Result loads invalid when procedure starts
// - Host trusts result from end event only
// - Code 2 needs slotted operation enabled
// - Host pulses trigger to launch slotted ack
// - Host should enable frame end event
// - Status bit 7 Clear_channel_check_done, bit 6 result
// - Events reach interrupt only when mask set
// - Command codes include 0x02, 0x16, 0x19
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module xsti_device import xsti_pkg::*; #(
  parameter int TRANS_N = TRANS_CYCLES
) (
  input wire logic core_clk, // Device clock
  input wire logic rst_b, // Async reset, active low
  xsti_link_if.device link, // Register port and pins to the host
  input wire logic rxPhrValid, // Pulse: valid PHY header received
  input wire logic rxAddrMatch, // Pulse: frame addresses pass filter
  input wire logic rxFrameDone, // Pulse: frame reception finished
  input wire logic rxFcsOk, // Level with rxFrameDone: FCS good
  input wire logic txDone, // Pulse: transmit transaction finished
  input wire logic [2:0] txResult, // Result code with txDone
  input wire logic ccaDone, // Pulse: clear channel check finished
  input wire logic ccaClear, // Level with ccaDone: channel idle
  output logic txStart, // Pulse: launch frame transmission
  output logic ackLaunch, // Pulse: launch slotted ack frame
  output logic [4:0] radioState, // Present state code
  output logic [CFG_N*8-1:0] cfgBits // Configuration bytes, entry 0 low
);
  xsti_state_t stateQ, targetQ, cmdTgt, pinTgt;
  logic [7:0] cntQ;
  logic [2:0] resultQ;
  logic [4:0] cmdQ;
  logic ccaDoneQ, ccaClearQ, matchQ, ackWaitQ;
  logic [7:0] evtQ, maskQ, rdataQ, readMux;
  logic [7:0] evtSet;
  logic rvalidQ, trigS1, trigS2, trigS3, trigRise;
  logic [7:0] cfgQ [CFG_N];
  logic accessOk, cmdWr, cmdOk, pinOk, txGo, aretBusy;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigS1 <= 1'b0;
      trigS2 <= 1'b0;
      trigS3 <= 1'b0;
    end else begin
      trigS1 <= link.trigPin;
      trigS2 <= trigS1;
      trigS3 <= trigS2;
    end
  end
  assign trigRise = trigS2 & ~trigS3;

  // Sleeping core has no register clock; writes are dropped and reads answer zero
  assign accessOk = (stateQ != ST_SLEEP) && (stateQ != ST_DEEP_SLEEP);
  assign cmdWr = link.regWe && accessOk && (link.regAddr == REG_CONTROL);
  assign aretBusy = (stateQ == ST_AUTO_RETRY_TX_BUSY);

  always_comb begin
    cmdOk = 1'b1;
    cmdTgt = ST_OFF;
    case (link.regWdata[4:0])
      CMD_FORCE_OFF: cmdTgt = ST_OFF;
      CMD_FORCE_PLL_ON: begin
        cmdTgt = ST_PLL_ON;
        cmdOk = (stateQ != ST_POWER_ON);
      end
      CMD_RX_ON: cmdTgt = ST_RX_ON;
      CMD_OFF: cmdTgt = ST_OFF;
      CMD_PLL_ON: cmdTgt = ST_PLL_ON;
      CMD_DEEP_PREP: cmdTgt = ST_DEEP_SLEEP_PREPARATION;
      CMD_AUTO_ACK_RX_ON: cmdTgt = ST_AUTO_ACK_RX_IDLE;
      CMD_AUTO_RETRY_TX_ON: cmdTgt = ST_AUTO_RETRY_TX_IDLE;
      default: cmdOk = 1'b0;
    endcase
  end

  always_comb begin
    pinOk = 1'b1;
    pinTgt = ST_OFF;
    case (stateQ)
      ST_OFF: pinTgt = ST_SLEEP;
      ST_SLEEP: pinTgt = ST_OFF;
      ST_DEEP_SLEEP_PREPARATION: pinTgt = ST_DEEP_SLEEP;
      ST_DEEP_SLEEP: pinTgt = ST_OFF;
      default: pinOk = 1'b0;
    endcase
  end

  assign txGo = ((cmdWr && link.regWdata[4:0] == CMD_TX_START) || trigRise)
    && (stateQ == ST_PLL_ON || stateQ == ST_AUTO_RETRY_TX_IDLE);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= ST_POWER_ON;
      targetQ <= ST_POWER_ON;
      cntQ <= 8'h00;
    end else if (txGo) begin
      stateQ <= (stateQ == ST_PLL_ON) ? ST_TX_BUSY : ST_AUTO_RETRY_TX_BUSY;
    end else if (cmdWr && cmdOk) begin
      stateQ <= ST_STATE_CHANGING;
      targetQ <= cmdTgt;
      cntQ <= 8'(TRANS_N);
    end else if (trigRise && pinOk) begin
      stateQ <= ST_STATE_CHANGING;
      targetQ <= pinTgt;
      cntQ <= 8'(TRANS_N);
    end else begin
      case (stateQ)
        ST_STATE_CHANGING: begin
          if (cntQ <= 8'h01) begin
            stateQ <= targetQ;
          end else begin
            cntQ <= cntQ - 8'h01;
          end
        end
        ST_RX_ON: if (rxPhrValid) stateQ <= ST_RX_BUSY;
        ST_RX_BUSY: if (rxFrameDone) stateQ <= ST_RX_ON;
        ST_AUTO_ACK_RX_IDLE: if (rxPhrValid) stateQ <= ST_AUTO_ACK_RX_BUSY;
        ST_AUTO_ACK_RX_BUSY: if (rxFrameDone) stateQ <= ST_AUTO_ACK_RX_IDLE;
        ST_TX_BUSY: if (txDone) stateQ <= ST_PLL_ON;
        ST_AUTO_RETRY_TX_BUSY: if (txDone) stateQ <= ST_AUTO_RETRY_TX_IDLE;
        default: stateQ <= stateQ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txStart <= 1'b0;
      ackLaunch <= 1'b0;
    end else begin
      txStart <= txGo;
      ackLaunch <= trigRise && ackWaitQ && (stateQ == ST_AUTO_ACK_RX_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdQ <= 5'h00;
    end else if (cmdWr) begin
      cmdQ <= link.regWdata[4:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resultQ <= RES_SUCCESS;
    end else if ((txGo && stateQ == ST_AUTO_RETRY_TX_IDLE) ||
                 (rxPhrValid && stateQ == ST_AUTO_ACK_RX_IDLE)) begin
      resultQ <= RES_INVALID;
    end else if (txDone && aretBusy) begin
      resultQ <= txResult;
    end else if (evtSet[EVT_END_BIT] && stateQ == ST_AUTO_ACK_RX_BUSY) begin
      resultQ <= cfgQ[CFG_IDX_RETRIES][SLOTTED_BIT] ?
        RES_OK_ACK_PENDING_SLOT : RES_SUCCESS;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackWaitQ <= 1'b0;
    end else if (evtSet[EVT_END_BIT] && stateQ == ST_AUTO_ACK_RX_BUSY) begin
      ackWaitQ <= cfgQ[CFG_IDX_RETRIES][SLOTTED_BIT];
    end else if (trigRise || stateQ != ST_AUTO_ACK_RX_IDLE) begin
      ackWaitQ <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      matchQ <= 1'b0;
    end else if (rxPhrValid) begin
      matchQ <= 1'b0;
    end else if (evtSet[EVT_MATCH_BIT]) begin
      matchQ <= 1'b1;
    end
  end

  always_comb begin
    evtSet = 8'h00;
    evtSet[EVT_START_BIT] = rxPhrValid && !aretBusy &&
      (stateQ == ST_RX_ON || stateQ == ST_AUTO_ACK_RX_IDLE);
    evtSet[EVT_MATCH_BIT] = rxAddrMatch && !aretBusy &&
      (stateQ == ST_RX_BUSY || stateQ == ST_AUTO_ACK_RX_BUSY);
    evtSet[EVT_END_BIT] = (rxFrameDone && stateQ == ST_RX_BUSY) ||
      (rxFrameDone && rxFcsOk && (matchQ || rxAddrMatch) &&
       stateQ == ST_AUTO_ACK_RX_BUSY) ||
      (txDone && (stateQ == ST_TX_BUSY || aretBusy));
    evtSet[EVT_CCA_BIT] = ccaDone && !aretBusy;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evtQ <= REG_RESET;
    end else if (link.regRe && accessOk && link.regAddr == REG_EVENTS) begin
      evtQ <= evtSet;
    end else begin
      evtQ <= evtQ | evtSet;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      maskQ <= REG_RESET;
    end else if (link.regWe && accessOk && link.regAddr == REG_MASK) begin
      maskQ <= link.regWdata;
    end
  end
  assign link.irqPin = |(evtQ & maskQ);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ccaDoneQ <= 1'b0;
      ccaClearQ <= 1'b0;
    end else if (ccaDone) begin
      ccaDoneQ <= 1'b1;
      ccaClearQ <= ccaClear;
    end else if (cmdWr) begin
      ccaDoneQ <= 1'b0;
      ccaClearQ <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < CFG_N; i++) begin : gCfg
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          cfgQ[i] <= REG_RESET;
        end else if (link.regWe && accessOk && link.regAddr == CFG_ADDR[i]) begin
          cfgQ[i] <= link.regWdata;
        end
      end
      assign cfgBits[i*8 +: 8] = cfgQ[i];
    end
  endgenerate

  always_comb begin
    readMux = 8'h00;
    case (link.regAddr)
      REG_STATUS: readMux = {ccaDoneQ, ccaClearQ, 1'b0, stateQ};
      REG_CONTROL: readMux = {resultQ, cmdQ};
      REG_MASK: readMux = maskQ;
      REG_EVENTS: readMux = evtQ;
      default: begin
        for (int i = 0; i < CFG_N; i++) begin
          if (link.regAddr == CFG_ADDR[i]) readMux = cfgQ[i];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalidQ <= 1'b0;
      rdataQ <= 8'h00;
    end else begin
      rvalidQ <= link.regRe;
      if (link.regRe) rdataQ <= accessOk ? readMux : 8'h00;
    end
  end
  assign link.regRvalid = rvalidQ;
  assign link.regRdata = rdataQ;
  assign radioState = stateQ;
endmodule
`default_nettype wire

// file: core/xsti_host.sv
`timescale 1ns/1ps
`default_nettype none
module xsti_host import xsti_pkg::*; #(
  parameter int TRIG_N = TRIG_CYCLES
) (
  input wire logic core_clk, // Host clock, same as device
  input wire logic rst_b, // Async reset, active low
  xsti_link_if.host link, // Register port and pins to the device
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  logic awHeldQ, wHeldQ, busyQ, refusedQ, readQ;
  logic [3:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [7:0] rdByteQ, lastStatusQ;
  logic [7:0] trigCntQ;
  logic doWrite, cmdGo, refuse;

  assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
  assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  assign cmdGo = doWrite && awAddrQ == HOST_REG_CMD && !busyQ;
  assign refuse = !wDataQ[HCMD_READ_BIT] &&
    wDataQ[HCMD_ADDR_LSB +: 6] == REG_CONTROL &&
    lastStatusQ[4:0] == ST_STATE_CHANGING;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddrQ == HOST_REG_TRIG ||
          (awAddrQ == HOST_REG_CMD && !busyQ)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyQ <= 1'b0;
      readQ <= 1'b0;
      refusedQ <= 1'b0;
      link.regWe <= 1'b0;
      link.regRe <= 1'b0;
      link.regAddr <= 6'h00;
      link.regWdata <= 8'h00;
      rdByteQ <= 8'h00;
      lastStatusQ <= 8'h00;
    end else begin
      link.regWe <= 1'b0;
      link.regRe <= 1'b0;
      if (cmdGo) begin
        refusedQ <= refuse;
        if (!refuse) begin
          busyQ <= wDataQ[HCMD_READ_BIT];
          readQ <= wDataQ[HCMD_READ_BIT];
          link.regAddr <= wDataQ[HCMD_ADDR_LSB +: 6];
          link.regWdata <= wDataQ[7:0];
          link.regRe <= wDataQ[HCMD_READ_BIT];
          link.regWe <= !wDataQ[HCMD_READ_BIT];
        end
      end else if (busyQ && readQ && link.regRvalid) begin
        busyQ <= 1'b0;
        rdByteQ <= link.regRdata;
        if (link.regAddr == REG_STATUS) lastStatusQ <= link.regRdata;
      end
    end
  end

  // Trigger pulse width is fixed; software times the slot boundary
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigCntQ <= 8'h00;
      link.trigPin <= 1'b0;
    end else if (doWrite && awAddrQ == HOST_REG_TRIG && wDataQ[0]) begin
      trigCntQ <= 8'(TRIG_N);
      link.trigPin <= 1'b1;
    end else if (trigCntQ > 8'h01) begin
      trigCntQ <= trigCntQ - 8'h01;
    end else begin
      trigCntQ <= 8'h00;
      link.trigPin <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      case (s_axi_araddr)
        HOST_REG_CMD: s_axi_rdata <= wDataQ;
        HOST_REG_STAT: s_axi_rdata <= {14'h0, refusedQ, link.irqPin,
                                       rdByteQ, 7'h0, busyQ};
        HOST_REG_TRIG: s_axi_rdata <= {31'h0, link.trigPin};
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/xsti_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module xsti_link_asserts import xsti_pkg::*; #(
  parameter int TRIG_N = TRIG_CYCLES
) (
  input wire logic core_clk, // Link clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [5:0] regAddr, // Register offset
  input wire logic [7:0] regWdata, // Write byte
  input wire logic regWe, // Write strobe
  input wire logic regRe, // Read strobe
  input wire logic [7:0] regRdata, // Read byte
  input wire logic regRvalid, // Read answer
  input wire logic trigPin, // Trigger pin
  input wire logic irqPin // Interrupt pin
);
  logic [5:0] rdAddr_q;
  logic lastChg_q;
  logic [7:0] mask_q;
  int trigLen_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) rdAddr_q <= 6'h00;
    else if (regRe) rdAddr_q <= regAddr;

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) lastChg_q <= 1'b0;
    else if (regRvalid && rdAddr_q == REG_STATUS)
      lastChg_q <= (regRdata[4:0] == 5'h1f);

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) mask_q <= 8'h00;
    else if (regWe && regAddr == REG_MASK) mask_q <= regWdata;

  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) trigLen_q <= 0;
    else trigLen_q <= trigPin ? trigLen_q + 1 : 0;

  read_answer_a: assert property (regRe |=> regRvalid)
    else $error("read strobe not answered next cycle");
  no_stray_answer_a: assert property (regRvalid |-> $past(regRe))
    else $error("read answer without read strobe");
  write_pulse_a: assert property (regWe |=> !regWe)
    else $error("write strobe longer than one cycle");
  status_reserved_a: assert property (
    regRvalid && rdAddr_q == REG_STATUS |-> regRdata[5] == 1'b0)
    else $error("status reserved bit set");
  state_code_a: assert property (
    regRvalid && rdAddr_q == REG_STATUS |-> regRdata[4:0] inside
    {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0f, 5'h10, 5'h11,
     5'h12, 5'h16, 5'h19, 5'h1f})
    else $error("reserved state code read");
  result_code_a: assert property (
    regRvalid && rdAddr_q == REG_CONTROL |-> regRdata[7:5] inside
    {3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7})
    else $error("reserved result code read");
  hold_in_change_a: assert property (
    regWe && regAddr == REG_CONTROL |-> !lastChg_q)
    else $error("command sent while state changing");
  mask_off_a: assert property (
    regWe && regAddr == REG_MASK && regWdata == 8'h00 |=> !irqPin)
    else $error("interrupt after mask cleared");
  irq_needs_mask_a: assert property (irqPin |-> mask_q != 8'h00)
    else $error("interrupt with empty mask");
  trig_width_a: assert property ($fell(trigPin) |-> trigLen_q == TRIG_N)
    else $error("trigger pulse width wrong");
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import xsti_pkg::*;;
  logic core_clk, rst_b;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic rxPhrValid, rxAddrMatch, rxFrameDone, rxFcsOk, txDone, ccaDone;
  logic ccaClear, txStart, ackLaunch;
  logic [2:0] txResult;
  logic [4:0] radioState;
  int num_errors, n_tests, txCnt, ackCnt;

  xsti_link_if link();
  xsti_host i_xsti_host (.core_clk(core_clk),
    .rst_b(rst_b), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  xsti_device #(.TRANS_N(40)) i_xsti_device (.core_clk(core_clk),
    .rst_b(rst_b), .link(link), .rxPhrValid(rxPhrValid),
    .rxAddrMatch(rxAddrMatch), .rxFrameDone(rxFrameDone),
    .rxFcsOk(rxFcsOk), .txDone(txDone), .txResult(txResult),
    .ccaDone(ccaDone), .ccaClear(ccaClear), .txStart(txStart),
    .ackLaunch(ackLaunch), .radioState(radioState), .cfgBits());
  xsti_link_asserts i_xsti_link_asserts (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWe(link.regWe), .regRe(link.regRe),
    .regRdata(link.regRdata), .regRvalid(link.regRvalid),
    .trigPin(link.trigPin), .irqPin(link.irqPin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (txStart === 1'b1) txCnt++;
    if (ackLaunch === 1'b1) ackCnt++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar, v;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge core_clk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
    end while (!v);
  endtask

  task automatic dev(input logic rd, input logic [5:0] off,
                     input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    axw(HOST_REG_CMD, {15'h0, rd, 2'b00, off, d}, r);
    s = 32'h1;
    for (int i = 0; i < 50 && s[0]; i++) axr(HOST_REG_STAT, s, r);
    q = s[15:8];
  endtask

  task automatic rdchk(input string nm, input logic [5:0] off,
                       input logic [7:0] m, e);
    logic [7:0] q;
    dev(1'b1, off, 8'h00, q);
    chk(nm, q & m, e);
  endtask

  task automatic wr8(input logic [5:0] off, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b0, off, d, q);
  endtask

  task automatic settle();
    logic [7:0] q;
    q = 8'h1f;
    for (int i = 0; i < 40 && q[4:0] == 5'h1f; i++)
      dev(1'b1, REG_STATUS, 8'h00, q);
  endtask

  task automatic ev(input logic [4:0] p);
    @(posedge core_clk);
    {rxPhrValid, rxAddrMatch, rxFrameDone, txDone, ccaDone} <= p;
    @(posedge core_clk);
    {rxPhrValid, rxAddrMatch, rxFrameDone, txDone, ccaDone} <= 5'h00;
  endtask

  task automatic frame(input logic m, input logic f);
    rxFcsOk <= f;
    ev(5'b10000);
    if (m) ev(5'b01000);
    ev(5'b00100);
  endtask

  task automatic wstate(input logic [4:0] s);
    for (int i = 0; i < 200 && radioState !== s; i++) @(negedge core_clk);
    chk("radioState", radioState, s);
    @(posedge core_clk);
  endtask

  task automatic t_reset();
    rdchk("status", REG_STATUS, 8'hff, 8'h00);
    rdchk("control", REG_CONTROL, 8'hff, 8'h00);
    wr8(REG_STATUS, 8'hff);
    rdchk("status ro", REG_STATUS, 8'hff, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_states();
    logic [31:0] s;
    logic [1:0] r;
    logic [4:0] cmds [5] = '{CMD_PLL_ON, CMD_RX_ON, CMD_OFF,
                             CMD_AUTO_RETRY_TX_ON, CMD_AUTO_ACK_RX_ON};
    wr8(REG_CONTROL, {3'h0, CMD_OFF});
    rdchk("changing", REG_STATUS, 8'h1f, 8'h1f);
    wr8(REG_CONTROL, {3'h0, CMD_PLL_ON});
    axr(HOST_REG_STAT, s, r);
    chk("refused", s[HSTAT_REFUSED_BIT], 1'b1);
    settle();
    rdchk("off", REG_STATUS, 8'h1f, ST_OFF);
    foreach (cmds[i]) begin
      wr8(REG_CONTROL, {3'h0, cmds[i]});
      settle();
      rdchk("state", REG_STATUS, 8'h1f, cmds[i]);
    end
    $display("test states done");
  endtask

  task automatic t_rx();
    logic [31:0] s;
    logic [1:0] r;
    wr8(REG_MASK, 8'h3c);
    rxFcsOk <= 1'b0;
    ev(5'b10000);
    rdchk("rx busy", REG_STATUS, 8'h1f, ST_AUTO_ACK_RX_BUSY);
    rdchk("rx invalid", REG_CONTROL, 8'he0, 8'he0);
    ev(5'b01000);
    ev(5'b00100);
    axr(HOST_REG_STAT, s, r);
    chk("irq on", s[HSTAT_IRQ_BIT], 1'b1);
    wr8(REG_MASK, 8'h00);
    axr(HOST_REG_STAT, s, r);
    chk("irq off", s[HSTAT_IRQ_BIT], 1'b0);
    rdchk("bad fcs", REG_EVENTS, 8'hff, 8'h24);
    frame(1'b0, 1'b1);
    rdchk("no match", REG_EVENTS, 8'hff, 8'h04);
    frame(1'b1, 1'b1);
    rdchk("good", REG_EVENTS, 8'hff, 8'h2c);
    rdchk("success", REG_CONTROL, 8'he0, {RES_SUCCESS, 5'h0});
    wr8(CFG_ADDR[CFG_IDX_RETRIES], 8'h01);
    frame(1'b1, 1'b1);
    rdchk("slot", REG_CONTROL, 8'he0, {RES_OK_ACK_PENDING_SLOT, 5'h0});
    rdchk("slot evt", REG_EVENTS, 8'hff, 8'h2c);
    axw(HOST_REG_TRIG, 32'h1, r);
    for (int i = 0; i < 50 && ackCnt == 0; i++) @(posedge core_clk);
    chk("ack launch", ackCnt, 1);
    $display("test rx done");
  endtask

  task automatic t_tx();
    logic [2:0] codes [4] = '{RES_SUCCESS, RES_OK_PENDING_DATA,
                              RES_CHANNEL_BUSY_FAILURE, RES_NO_ACK};
    wr8(REG_CONTROL, {3'h0, CMD_AUTO_RETRY_TX_ON});
    settle();
    foreach (codes[i]) begin
      wr8(REG_CONTROL, {3'h0, CMD_TX_START});
      rdchk("tx busy", REG_STATUS, 8'h1f, ST_AUTO_RETRY_TX_BUSY);
      rdchk("tx invalid", REG_CONTROL, 8'he0, 8'he0);
      ev(5'b11001);
      txResult <= codes[i];
      ev(5'b00010);
      rdchk("tx events", REG_EVENTS, 8'hff, 8'h08);
      rdchk("tx result", REG_CONTROL, 8'he0, {codes[i], 5'h0});
    end
    chk("tx starts", txCnt, 4);
    $display("test tx done");
  endtask

  task automatic t_sleep();
    logic [31:0] d;
    logic [1:0] r;
    wr8(REG_CONTROL, {3'h0, CMD_OFF});
    settle();
    ccaClear <= 1'b1;
    ev(5'b00001);
    rdchk("cca", REG_STATUS, 8'hff, 8'hc8);
    axw(HOST_REG_TRIG, 32'h1, r);
    wstate(ST_SLEEP);
    rdchk("asleep", REG_STATUS, 8'hff, 8'h00);
    axw(HOST_REG_TRIG, 32'h1, r);
    wstate(ST_OFF);
    axr(4'hc, d, r);
    chk("unmapped", r, RESP_SLVERR);
    axw(HOST_REG_STAT, 32'h0, r);
    chk("stat write", r, RESP_SLVERR);
    $display("test sleep done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {rst_b, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {rxPhrValid, rxAddrMatch, rxFrameDone, rxFcsOk, txDone} = '0;
    {ccaDone, ccaClear, txResult} = '0;
    {num_errors, n_tests, txCnt, ackCnt} = '0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_states();
    t_rx();
    t_tx();
    t_sleep();
    print_verdict();
  end

  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
